// >>> design/oscdiv_defs.svh
`ifndef OSCDIV_DEFS_SVH
`define OSCDIV_DEFS_SVH
`define OSCDIV_A_CTRL      4'h0
`define OSCDIV_A_DIV       4'h1
`define OSCDIV_A_TUN       4'h2
`define OSCDIV_A_IRQ       4'h3
`define OSCDIV_A_STAT      4'h4
`define OSCDIV_KEY_H1      8'h78
`define OSCDIV_KEY_H2      8'h9A
`define OSCDIV_KEY_L1      8'h46
`define OSCDIV_KEY_L2      8'h57
`define OSCDIV_DIV_RST     16'h0100
`define OSCDIV_DIV_MASK    16'hFFC0
`define OSCDIV_TUN_MASK    16'h003F
`define OSCDIV_HANDOVER    4'hA
`define OSCDIV_OST_DEF     1024
`define OSCDIV_WAIT_DEF    65535
`endif

// >>> design/oscdiv_pkg.sv
package oscdiv_pkg;
   typedef enum logic [2:0] {
      OSCDIV_SRC_FRC     = 3'h0,
      OSCDIV_SRC_FAST_RC_WITH_PLL  = 3'h1,
      OSCDIV_SRC_PRI     = 3'h2,
      OSCDIV_SRC_PRIPLL  = 3'h3,
      OSCDIV_SRC_SEC     = 3'h4,
      OSCDIV_SRC_LOW_POWER_RC_OSC    = 3'h5,
      OSCDIV_SRC_RSVD    = 3'h6,
      OSCDIV_SRC_FRCDIV  = 3'h7
   } oscdiv_src_t;
   typedef enum logic [2:0] {
      OSCDIV_IDLE  = 3'h0,
      OSCDIV_START = 3'h1,
      OSCDIV_WAIT  = 3'h2,
      OSCDIV_COUNT = 3'h3,
      OSCDIV_DONE  = 3'h4
   } oscdiv_state_t;
endpackage

// >>> design/oscdiv_top.sv
`include "oscdiv_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module oscdiv_top
   import oscdiv_pkg::*;
#(
   parameter int OST_CYCLES  = `OSCDIV_OST_DEF,
   parameter int WAIT_LIMIT  = `OSCDIV_WAIT_DEF
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Register port
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   // Fuses (static)
   input  wire logic        switch_enable_fuse,
   input  wire logic        monitor_fuse,
   input  wire logic [2:0]  initial_source_fuse,
   input  wire logic [1:0]  primary_submode_fuse,
   input  wire logic        watchdog_enable,
   // Oscillator status and events (asynchronous)
   input  wire logic        pll_locked_in,
   input  wire logic        new_clk_tick,
   input  wire logic        interrupt_in,
   input  wire logic        clock_fail_in,
   // Clock control outputs
   output logic [4:0]       osc_run,
   output logic [2:0]       sysclk_source,
   output logic [7:0]       periph_ratio,
   output logic [8:0]       fast_rc_divisor,
   output logic [3:0]       usb_sysclk_divisor,
   output logic [5:0]       fast_rc_trim,
   output logic [1:0]       primary_submode,
   output logic             switch_busy
);
   // Synchronisers for asynchronous inputs
   logic [3:0] s1_r;
   logic [3:0] s2_r;
   logic [3:0] s3_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 4'h0;
         s2_r <= 4'h0;
         s3_r <= 4'h0;
      end else begin
         s1_r <= {clock_fail_in, interrupt_in, new_clk_tick, pll_locked_in};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   logic lock_s;
   logic tick_p;
   logic irq_p;
   logic fail_p;
   assign lock_s = s2_r[0];
   assign tick_p = s2_r[1] & ~s3_r[1];
   assign irq_p  = s2_r[2] & ~s3_r[2];
   assign fail_p = s2_r[3] & ~s3_r[3];

   // Fuses caught once after reset release
   logic       fuse_cap_r;
   logic       sw_en_r;
   logic       failsafe_monitor_r;
   logic [1:0] submode_r;
   logic       fuse_cap_nxt;
   logic       sw_en_nxt;
   logic       failsafe_monitor_nxt;
   logic [1:0] submode_nxt;

   // Control state
   logic [15:0]   div_r;
   logic [15:0]   div_nxt;
   logic [5:0]    tun_r;
   logic [5:0]    tun_nxt;
   logic [2:0]    cur_r;
   logic [2:0]    cur_nxt;
   logic [2:0]    nxt_src_r;
   logic [2:0]    nxt_src_nxt;
   logic          freeze_r;
   logic          freeze_nxt;
   logic          lock_r;
   logic          lock_nxt;
   logic          cf_r;
   logic          cf_nxt;
   logic          secondary_osc_en_r;
   logic          secondary_osc_en_nxt;
   logic          req_r;
   logic          req_nxt;
   logic [1:0]    hkey_r;
   logic [1:0]    hkey_nxt;
   logic [1:0]    lkey_r;
   logic [1:0]    lkey_nxt;
   logic [4:0]    run_r;
   logic [4:0]    run_nxt;
   oscdiv_state_t st_r;
   oscdiv_state_t st_nxt;
   logic [15:0]   cnt_r;
   logic [15:0]   cnt_nxt;
   logic [15:0]   rdata_r;
   logic [15:0]   rdata_nxt;

   function automatic logic [4:0] src_osc(input logic [2:0] s);
      // One bit per oscillator: 0 fast RC, 1 primary, 2 secondary, 3 low-power RC, 4 PLL
      logic [4:0] m;
      m = 5'h00;
      case (s)
         OSCDIV_SRC_FRC, OSCDIV_SRC_FRCDIV: m = 5'h01;
         OSCDIV_SRC_FAST_RC_WITH_PLL:                 m = 5'h11;
         OSCDIV_SRC_PRI:                    m = 5'h02;
         OSCDIV_SRC_PRIPLL:                 m = 5'h12;
         OSCDIV_SRC_SEC:                    m = 5'h04;
         OSCDIV_SRC_LOW_POWER_RC_OSC:                   m = 5'h08;
         default:                           m = 5'h00;
      endcase
      return m;
   endfunction

   function automatic logic is_pll(input logic [2:0] s);
      return (s == OSCDIV_SRC_FAST_RC_WITH_PLL) || (s == OSCDIV_SRC_PRIPLL);
   endfunction

   always_comb begin
      fuse_cap_nxt = 1'b1;
      sw_en_nxt    = sw_en_r;
      failsafe_monitor_nxt     = failsafe_monitor_r;
      submode_nxt  = submode_r;
      if (!fuse_cap_r) begin
         sw_en_nxt   = ~switch_enable_fuse;
         failsafe_monitor_nxt    = ~switch_enable_fuse & ~monitor_fuse;
         submode_nxt = primary_submode_fuse;
      end
   end

   always_comb begin
      div_nxt     = div_r;
      tun_nxt     = tun_r;
      cur_nxt     = cur_r;
      nxt_src_nxt = nxt_src_r;
      freeze_nxt  = freeze_r;
      lock_nxt    = lock_r;
      cf_nxt      = cf_r;
      secondary_osc_en_nxt = secondary_osc_en_r;
      req_nxt     = req_r;
      hkey_nxt    = 2'h0;
      lkey_nxt    = 2'h0;
      run_nxt     = run_r;
      st_nxt      = st_r;
      cnt_nxt     = cnt_r;
      rdata_nxt   = 16'h0000;

      if (!fuse_cap_r) begin
         cur_nxt     = initial_source_fuse;
         nxt_src_nxt = initial_source_fuse;
         run_nxt     = src_osc(initial_source_fuse);
      end

      // Lock status tracks the PLL only while a PLL source is in use
      if (st_r == OSCDIV_IDLE)
         lock_nxt = is_pll(cur_r) & lock_s;

      if (wr && addr == `OSCDIV_A_CTRL) begin
         if (hkey_r == 2'h2) begin
            if (sw_en_r && !(freeze_r && failsafe_monitor_r))
               nxt_src_nxt = wdata[10:8];
         end else if (wdata[15:8] == `OSCDIV_KEY_H1) begin
            hkey_nxt = 2'h1;
         end else if (hkey_r == 2'h1 && wdata[15:8] == `OSCDIV_KEY_H2) begin
            hkey_nxt = 2'h2;
         end
         if (lkey_r == 2'h2) begin
            secondary_osc_en_nxt = wdata[1];
            if (wdata[7])
               freeze_nxt = 1'b1;
            // Clear-only fail flag
            if (!wdata[3])
               cf_nxt = 1'b0;
            if (wdata[0] && sw_en_r && !(freeze_r && failsafe_monitor_r))
               req_nxt = 1'b1;
         end else if (wdata[7:0] == `OSCDIV_KEY_L1) begin
            lkey_nxt = 2'h1;
         end else if (lkey_r == 2'h1 && wdata[7:0] == `OSCDIV_KEY_L2) begin
            lkey_nxt = 2'h2;
         end
      end else if (wr && addr == `OSCDIV_A_DIV) begin
         div_nxt = wdata & `OSCDIV_DIV_MASK;
      end else if (wr && addr == `OSCDIV_A_TUN) begin
         tun_nxt = wdata[5:0];
      end

      // interrupt recovery, wins over a write
      if (irq_p && div_r[15])
         div_nxt[11] = 1'b0;

      // Fail detection only while monitor on; set wins over a software clear, but a switch start clears it
      if (fail_p && failsafe_monitor_r)
         cf_nxt = 1'b1;

      // sequencer runs beside the CPU, no stall
      case (st_r)
         OSCDIV_IDLE: begin
            if (req_r) begin
               if (nxt_src_r == cur_r || nxt_src_r == OSCDIV_SRC_RSVD) begin
                  req_nxt = 1'b0;
               end else begin
                  lock_nxt = 1'b0;
                  cf_nxt   = 1'b0;
                  st_nxt   = OSCDIV_START;
               end
            end
         end
         OSCDIV_START: begin
            cnt_nxt = 16'h0000;
            if ((run_r & src_osc(nxt_src_r) & 5'h02) == 5'h00 &&
                (src_osc(nxt_src_r) & 5'h02) != 5'h00 && submode_r != 2'h0)
               cnt_nxt = 16'(OST_CYCLES);
            run_nxt = run_r | src_osc(nxt_src_r);
            st_nxt  = OSCDIV_WAIT;
         end
         OSCDIV_WAIT: begin
            if (cnt_r != 16'h0000) begin
               cnt_nxt = cnt_r - 16'h0001;
            end else if (!is_pll(nxt_src_r) || lock_s) begin
               lock_nxt = is_pll(nxt_src_r);
               st_nxt   = OSCDIV_COUNT;
               cnt_nxt  = 16'h0000;
            end
         end
         OSCDIV_COUNT: begin
            // ten ticks of the new clock
            if (tick_p) begin
               cnt_nxt = cnt_r + 16'h0001;
               if (cnt_r[3:0] == `OSCDIV_HANDOVER - 4'h1)
                  st_nxt = OSCDIV_DONE;
            end
         end
         OSCDIV_DONE: begin
            cur_nxt = nxt_src_r;
            req_nxt = 1'b0;
            run_nxt = src_osc(nxt_src_r);
            if (watchdog_enable || failsafe_monitor_r)
               run_nxt[3] = 1'b1;
            if (secondary_osc_en_r)
               run_nxt[2] = 1'b1;
            st_nxt = OSCDIV_IDLE;
         end
         default: st_nxt = OSCDIV_IDLE;
      endcase
      // no lock: keep waiting, request set
      // No time-out: only a reset, a lock or a new non-PLL selection frees the sequencer
      if (st_r == OSCDIV_WAIT && cnt_r == 16'h0000 && is_pll(nxt_src_r) && !lock_s)
         st_nxt = OSCDIV_WAIT;

      if (rd) begin
         if (addr == `OSCDIV_A_CTRL)
            rdata_nxt = {1'b0, cur_r, 1'b0, nxt_src_r, freeze_r, 1'b0, lock_r,
                         1'b0, cf_r, 1'b0, secondary_osc_en_r, req_r};
         else if (addr == `OSCDIV_A_DIV)
            rdata_nxt = div_r;
         else if (addr == `OSCDIV_A_TUN)
            rdata_nxt = {10'h000, tun_r};
         else if (addr == `OSCDIV_A_IRQ)
            // Spare index, reads zero
            rdata_nxt = 16'h0000;
         else if (addr == `OSCDIV_A_STAT)
            rdata_nxt = {8'h00, sw_en_r, failsafe_monitor_r, submode_r, 1'b0, st_r};
         else
            rdata_nxt = 16'h0000;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fuse_cap_r <= 1'b0;
         sw_en_r    <= 1'b0;
         failsafe_monitor_r     <= 1'b0;
         submode_r  <= 2'h3;
         div_r      <= `OSCDIV_DIV_RST;
         tun_r      <= 6'h00;
         cur_r      <= 3'h7;
         nxt_src_r  <= 3'h7;
         freeze_r   <= 1'b0;
         lock_r     <= 1'b0;
         cf_r       <= 1'b0;
         secondary_osc_en_r  <= 1'b0;
         req_r      <= 1'b0;
         hkey_r     <= 2'h0;
         lkey_r     <= 2'h0;
         run_r      <= 5'h01;
         st_r       <= OSCDIV_IDLE;
         cnt_r      <= 16'h0000;
         rdata_r    <= 16'h0000;
      end else begin
         fuse_cap_r <= fuse_cap_nxt;
         sw_en_r    <= sw_en_nxt;
         failsafe_monitor_r     <= failsafe_monitor_nxt;
         submode_r  <= submode_nxt;
         div_r      <= div_nxt;
         tun_r      <= tun_nxt;
         cur_r      <= cur_nxt;
         nxt_src_r  <= nxt_src_nxt;
         freeze_r   <= freeze_nxt;
         lock_r     <= lock_nxt;
         cf_r       <= cf_nxt;
         secondary_osc_en_r  <= secondary_osc_en_nxt;
         req_r      <= req_nxt;
         hkey_r     <= hkey_nxt;
         lkey_r     <= lkey_nxt;
         run_r      <= run_nxt;
         st_r       <= st_nxt;
         cnt_r      <= cnt_nxt;
         rdata_r    <= rdata_nxt;
      end
   end

   // Registered decoded outputs
   logic [7:0] ratio_r;
   logic [7:0] ratio_nxt;
   logic [8:0] frcd_r;
   logic [8:0] frcd_nxt;
   logic [3:0] usbd_r;
   logic [3:0] usbd_nxt;
   always_comb begin
      // ratio only while enabled; power of two
      ratio_nxt = div_r[11] ? (8'h01 << div_r[14:12]) : 8'h01;
      frcd_nxt  = (div_r[10:8] == 3'h7) ? 9'h100 : (9'h001 << div_r[10:8]);
      // USB branch postscale; left to software
      usbd_nxt  = 4'h1 << div_r[7:6];
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ratio_r <= 8'h01;
         frcd_r  <= 9'h002;
         usbd_r  <= 4'h1;
      end else begin
         ratio_r <= ratio_nxt;
         frcd_r  <= frcd_nxt;
         usbd_r  <= usbd_nxt;
      end
   end

   assign rdata              = rdata_r;
   assign osc_run            = run_r;
   assign sysclk_source      = cur_r;
   assign periph_ratio       = ratio_r;
   assign fast_rc_divisor    = frcd_r;
   assign usb_sysclk_divisor = usbd_r;
   assign fast_rc_trim       = tun_r;
   assign primary_submode    = submode_r;
   assign switch_busy        = req_r;
endmodule
`default_nettype wire

// >>> verif/oscdiv_props.sv
`timescale 1ns/1ps
`default_nettype none
module oscdiv_props (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Register port
   input wire logic [3:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] rdata,
   // Fuses and events
   input wire logic        switch_enable_fuse,
   input wire logic [2:0]  initial_source_fuse,
   input wire logic        new_clk_tick,
   // Outputs under watch
   input wire logic [2:0]  sysclk_source,
   input wire logic [7:0]  periph_ratio,
   input wire logic [8:0]  fast_rc_divisor,
   input wire logic [3:0]  usb_sysclk_divisor,
   input wire logic [5:0]  fast_rc_trim,
   input wire logic        switch_busy
);
   logic [15:0] div_w_r, div_w_nxt, tun_w_r, tun_w_nxt;
   logic [7:0]  tick_cnt_r, tick_cnt_nxt;
   logic        tick_q_r;

   function automatic logic [8:0] frc_div(input logic [2:0] c);
      return (c == 3'h7) ? 9'h100 : 9'h001 << c;
   endfunction

   // Raw ticks lead the synchroniser, so the count is only an upper bound
   always_comb begin
      div_w_nxt = (wr && addr == 4'h1) ? wdata : div_w_r;
      tun_w_nxt = (wr && addr == 4'h2) ? wdata : tun_w_r;
      tick_cnt_nxt = switch_busy ? tick_cnt_r : 8'h00;
      if (switch_busy && new_clk_tick && !tick_q_r && tick_cnt_r != 8'hFF)
         tick_cnt_nxt = tick_cnt_r + 8'h01;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_w_r    <= 16'h0000;
         tun_w_r    <= 16'h0000;
         tick_cnt_r <= 8'h00;
         tick_q_r   <= 1'b0;
      end else begin
         div_w_r    <= div_w_nxt;
         tun_w_r    <= tun_w_nxt;
         tick_cnt_r <= tick_cnt_nxt;
         tick_q_r   <= new_clk_tick;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   ratio_apply_a: assert property (wr && addr == 4'h1 |-> ##[1:2]
      periph_ratio == (div_w_r[11] ? 8'h01 << div_w_r[14:12] : 8'h01))
      else $error("peripheral ratio does not follow divider write");
   frc_div_a: assert property (wr && addr == 4'h1 |-> ##[1:2]
      fast_rc_divisor == frc_div(div_w_r[10:8]))
      else $error("fast RC divisor does not follow divider write");
   usb_div_a: assert property (wr && addr == 4'h1 |-> ##[1:2]
      usb_sysclk_divisor == 4'h1 << div_w_r[7:6])
      else $error("USB branch divisor does not follow divider write");
   trim_follow_a: assert property (wr && addr == 4'h2 |-> ##[1:2]
      fast_rc_trim == tun_w_r[5:0])
      else $error("trim output does not follow tune write");
   unimpl_zero_a: assert property (rd && (addr == 4'h1 || addr == 4'h2) |=>
      (rdata & ($past(addr) == 4'h1 ? 16'h003F : 16'hFFC0)) == 16'h0000)
      else $error("unimplemented bits read nonzero");
   rdata_idle_a: assert property (!rd |=> rdata == 16'h0000)
      else $error("read data present without a read");
   switch_off_a: assert property (switch_enable_fuse |-> !switch_busy)
      else $error("switch request set while switching disabled");
   cur_fuse_a: assert property (switch_enable_fuse && $past(rst_n) && $past(rst_n, 2)
      |-> sysclk_source == initial_source_fuse)
      else $error("current source differs from fuse while switching disabled");
   cur_change_a: assert property ($changed(sysclk_source) && $past(rst_n)
      && $past(rst_n, 2) |-> $fell(switch_busy))
      else $error("current source changed outside a completed switch");
   handover_wait_a: assert property ($fell(switch_busy) && $changed(sysclk_source)
      |-> tick_cnt_r >= 8'h0A)
      else $error("handover before ten new-clock cycles");

   cover property ($fell(switch_busy) && $changed(sysclk_source));
   cover property (wr && addr == 4'h1 && wdata[11]);
   cover property (switch_busy [*8]);
endmodule

bind oscdiv_top oscdiv_props oscdiv_props_inst (
   .clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .switch_enable_fuse,
   .initial_source_fuse, .new_clk_tick, .sysclk_source, .periph_ratio,
   .fast_rc_divisor, .usb_sysclk_divisor, .fast_rc_trim, .switch_busy);
`default_nettype wire

// >>> verif/oscdiv_tb.sv
`include "oscdiv_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module oscdiv_tb
   import oscdiv_pkg::*;
;
   typedef struct packed {
      logic [15:0] din;
      logic [7:0]  ratio;
      logic [8:0]  fast_rc_osc;
      logic [3:0]  usb;
   } oscdiv_row_t;
   // Unimplemented bits are written as ones on purpose
   // USB kept off, so div4 and div8 codes are legal
   oscdiv_row_t rows [9] = '{
      '{16'h083F, 8'h01, 9'h001, 4'h1}, '{16'h197F, 8'h02, 9'h002, 4'h2},
      '{16'h2ABF, 8'h04, 9'h004, 4'h4}, '{16'h3BFF, 8'h08, 9'h008, 4'h8},
      '{16'h4C3F, 8'h10, 9'h010, 4'h1}, '{16'h5D7F, 8'h20, 9'h020, 4'h2},
      '{16'h6EBF, 8'h40, 9'h040, 4'h4}, '{16'h7FFF, 8'h80, 9'h100, 4'h8},
      '{16'h703F, 8'h01, 9'h001, 4'h1}};
   logic        clk, rst_n, wr, rd, switch_enable_fuse, monitor_fuse, watchdog_enable;
   logic        pll_locked_in, new_clk_tick, interrupt_in, clock_fail_in, switch_busy;
   logic [3:0]  addr, usb_sysclk_divisor;
   logic [15:0] wdata, rdata;
   logic [2:0]  initial_source_fuse, sysclk_source;
   logic [1:0]  primary_submode_fuse, primary_submode;
   logic [4:0]  osc_run;
   logic [7:0]  periph_ratio;
   logic [8:0]  fast_rc_divisor;
   logic [5:0]  fast_rc_trim;
   int          errors, samples_checked, n;

   oscdiv_top #(.OST_CYCLES(4), .WAIT_LIMIT(64)) oscdiv_top_inst (
      .clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .switch_enable_fuse, .monitor_fuse,
      .initial_source_fuse, .primary_submode_fuse, .watchdog_enable, .pll_locked_in,
      .new_clk_tick, .interrupt_in, .clock_fail_in, .osc_run, .sysclk_source,
      .periph_ratio, .fast_rc_divisor, .usb_sysclk_divisor, .fast_rc_trim,
      .primary_submode, .switch_busy);

   always #50 clk = ~clk;
   // Phase unrelated to clk; slow enough that every edge is sampled
   // Fractional half period keeps its edges off clk edges for the whole run
   always #317.3 new_clk_tick = ~new_clk_tick;

   task automatic chk(input string what, input logic [15:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      wr <= 1'b1;
      rd <= 1'b0;
      addr <= a;
      wdata <= d;
      @(posedge clk);
   endtask
   task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] m, exp);
      wr <= 1'b0;
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(what, rdata & m, exp);
      @(posedge clk);
   endtask
   task automatic idle(input int c);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (c) @(posedge clk);
   endtask
   task automatic set_next(input logic [2:0] s);
      // keys back to back, then write
      wr_reg(4'h0, 16'h7800);
      wr_reg(4'h0, 16'h9A00);
      wr_reg(4'h0, {5'h00, s, 8'h00});
      wr_reg(4'h0, 16'h0046);
      wr_reg(4'h0, 16'h0057);
      wr_reg(4'h0, 16'h0009);
      idle(1);
   endtask
   // Ends on a falling edge so that outputs are settled for the caller
   task automatic wait_idle(input int lim);
      n = 0;
      while (switch_busy !== 1'b0 && n < lim) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
   endtask
   task automatic do_reset(input logic sw);
      rst_n <= 1'b0;
      switch_enable_fuse <= sw;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   task automatic done(input string t);
      $display("test %s finished, mismatches so far %0d", t, errors);
   endtask
   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      #1000000;
      errors++;
      final_report();
   end

   initial begin
      {clk, rst_n, wr, rd, addr, wdata, watchdog_enable, pll_locked_in} = '0;
      {new_clk_tick, interrupt_in, clock_fail_in, errors, samples_checked} = '0;
      {switch_enable_fuse, monitor_fuse, primary_submode_fuse} = 4'hD;
      initial_source_fuse = OSCDIV_SRC_LOW_POWER_RC_OSC;
      do_reset(1'b1);
      @(negedge clk);
      chk("reset ratio", periph_ratio, 8'h01);
      chk("reset fast RC divisor", fast_rc_divisor, 9'h002);
      chk("reset USB divisor", usb_sysclk_divisor, 4'h1);
      chk("submode", primary_submode, 2'h1);
      @(posedge clk);
      rd_chk("divider reset", 4'h1, 16'hFFFF, `OSCDIV_DIV_RST);
      rd_chk("tune reset", 4'h2, 16'hFFFF, 16'h0000);
      rd_chk("unmapped", 4'hF, 16'hFFFF, 16'h0000);
      rd_chk("spare index", 4'h3, 16'hFFFF, 16'h0000);
      rd_chk("status disabled", 4'h4, 16'hFFFF, 16'h0010);
      set_next(OSCDIV_SRC_PRI);
      idle(20);
      rd_chk("control disabled", 4'h0, 16'h7001, 16'h5000);
      done("switching disabled");
      foreach (rows[i]) begin
         wr_reg(4'h1, rows[i].din);
         rd_chk("divider readback", 4'h1, 16'hFFFF, rows[i].din & `OSCDIV_DIV_MASK);
         @(negedge clk);
         chk("ratio", periph_ratio, rows[i].ratio);
         chk("fast RC divisor", fast_rc_divisor, rows[i].fast_rc_osc);
         chk("USB divisor", usb_sysclk_divisor, rows[i].usb);
         @(posedge clk);
      end
      for (int i = 0; i < 2; i++) begin
         wr_reg(4'h2, i ? 16'hFFE0 : 16'hFFDF);
         rd_chk("tune readback", 4'h2, 16'hFFFF, i ? 16'h0020 : 16'h001F);
         @(negedge clk);
         chk("trim", fast_rc_trim, i ? 6'h20 : 6'h1F);
         @(posedge clk);
      end
      done("divider table");
      for (int i = 0; i < 2; i++) begin
         wr_reg(4'h1, i ? 16'h3800 : 16'hB800);
         idle(2);
         interrupt_in <= 1'b1;
         idle(3);
         interrupt_in <= 1'b0;
         idle(4);
         rd_chk("divider after interrupt", 4'h1, 16'hFFFF, i ? 16'h3800 : 16'hB000);
         @(negedge clk);
         chk("ratio after interrupt", periph_ratio, i ? 8'h08 : 8'h01);
         @(posedge clk);
      end
      done("interrupt recovery");
      initial_source_fuse <= OSCDIV_SRC_FRC;
      monitor_fuse <= 1'b0;
      do_reset(1'b0);
      rd_chk("status enabled", 4'h4, 16'hFFFF, 16'h00D0);
      wr_reg(4'h0, 16'h0200);
      idle(2);
      rd_chk("next without unlock", 4'h0, 16'h0701, 16'h0000);
      set_next(OSCDIV_SRC_PRI);
      wait_idle(300);
      chk("switch finished", n < 300, 1'b1);
      chk("source after switch", sysclk_source, OSCDIV_SRC_PRI);
      chk("running after switch", osc_run, 5'h0A);
      @(posedge clk);
      rd_chk("control after switch", 4'h0, 16'h7701, 16'h2200);
      set_next(OSCDIV_SRC_PRI);
      wait_idle(20);
      chk("redundant abort quick", n < 20, 1'b1);
      chk("source after abort", sysclk_source, OSCDIV_SRC_PRI);
      @(posedge clk);
      done("switch to primary");
      clock_fail_in <= 1'b1;
      idle(4);
      clock_fail_in <= 1'b0;
      idle(2);
      rd_chk("fail flag set", 4'h0, 16'h0008, 16'h0008);
      // primary to its PLL, never to fast RC PLL
      set_next(OSCDIV_SRC_PRIPLL);
      idle(150);
      @(negedge clk);
      chk("request held", switch_busy, 1'b1);
      chk("old source kept", sysclk_source, OSCDIV_SRC_PRI);
      @(posedge clk);
      rd_chk("lock and fail cleared", 4'h0, 16'h0029, 16'h0001);
      pll_locked_in <= 1'b1;
      wait_idle(300);
      chk("PLL switch finished", n < 300, 1'b1);
      chk("source after lock", sysclk_source, OSCDIV_SRC_PRIPLL);
      chk("running with PLL", osc_run, 5'h1A);
      @(posedge clk);
      done("PLL switch");
      wr_reg(4'h0, 16'h0046);
      wr_reg(4'h0, 16'h0057);
      wr_reg(4'h0, 16'h0088);
      set_next(OSCDIV_SRC_FRC);
      wait_idle(20);
      chk("frozen source", sysclk_source, OSCDIV_SRC_PRIPLL);
      chk("frozen request", switch_busy, 1'b0);
      @(posedge clk);
      done("selection freeze");
      final_report();
   end
endmodule
`default_nettype wire
